// ==== rtl/icn_defines.vh ====
// Constants for the input change notification block.
// Assumes inclusion by bare name from rtl/.
`ifndef ICN_DEFINES_VH
`define ICN_DEFINES_VH
`define ICN_MAX_PINS       21
`define ICN_LOW_BITS       16
`define ICN_HIGH_BITS      5
`define ICN_ENABLE_RESET   16'h0000
`define ICN_PULLUP_RESET   16'h0000
`define ICN_SETTLE_CYCLES  2'h3
`endif

// ==== rtl/icn_sync.v ====
// Two-flop level synchroniser for one vector of pins.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module icn_sync #(
  parameter WIDTH = 21
) (
  input  wire             clk,
  input  wire             reset,
  input  wire [WIDTH-1:0] d,
  output reg  [WIDTH-1:0] q
);
  reg [WIDTH-1:0] meta;
  always @(posedge clk) begin
    if (reset) begin
      meta <= {WIDTH{1'b0}};
      q    <= {WIDTH{1'b0}};
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule // icn_sync
`default_nettype wire

// ==== rtl/icn_notifier.v ====
// Input change notification: per-pin change detect and weak pull-up control.
// Assumes inputs synchronous to SYS_CLK, pads apply the pull-up enables.
// How it works
// - Enabled pin change raises interrupt request
// - Clocked sleep reference catches raw pin changes while asleep
// - Up to 21 pins, count is parameter
// - Two enable words gate each pin's request
// - Two pull-up words drive per-pin pull-ups
`timescale 1ns/10ps
`default_nettype none
`include "icn_defines.vh"
module icn_notifier #(
  parameter NUM_PINS = `ICN_MAX_PINS
) (
  // Clock and reset
  input  wire                 SYS_CLK,
  input  wire                 RESET,
  // Power state
  input  wire                 SLEEP,
  // Monitored input pins
  input  wire [NUM_PINS-1:0]  MONITORED_INPUT_PIN,
  // Software control words
  input  wire [15:0]          CHANGE_IRQ_ENABLE_LOW,
  input  wire [15:0]          CHANGE_IRQ_ENABLE_HIGH,
  input  wire [15:0]          WEAK_PULLUP_ENABLE_LOW,
  input  wire [15:0]          WEAK_PULLUP_ENABLE_HIGH,
  // Pending acknowledge
  input  wire                 IRQ_CLEAR,
  // Pull-up controls to the pads
  output reg  [NUM_PINS-1:0]  PULLUP_ON,
  // Interrupt request, wake and per-pin change flags
  output reg                  CHANGE_IRQ,
  output reg                  WAKE_REQUEST,
  output reg  [NUM_PINS-1:0]  PIN_STATE_CHANGE
);
  // One-hot sleep tracking states
  localparam [2:0] ST_AWAKE  = 3'h1;
  localparam [2:0] ST_ENTER  = 3'h2;
  localparam [2:0] ST_ASLEEP = 3'h4;

  // Pin vector from a high and low control word pair
  function [NUM_PINS-1:0] pick_pins;
    input [15:0] high_word;
    input [15:0] low_word;
    reg   [31:0] both;
    begin
      both      = {high_word, low_word};
      pick_pins = both[NUM_PINS-1:0];
    end
  endfunction

  // Enabled pins whose level differs from a reference
  function [NUM_PINS-1:0] diff_pins;
    input [NUM_PINS-1:0] level_now;
    input [NUM_PINS-1:0] level_ref;
    input [NUM_PINS-1:0] mask;
    begin
      diff_pins = (level_now ^ level_ref) & mask;
    end
  endfunction

  // Control words as pin vectors
  wire [NUM_PINS-1:0] enable;
  wire [NUM_PINS-1:0] pullup_req;
  // Synchronised pins and change detect
  wire [NUM_PINS-1:0] pin_sync;
  reg  [NUM_PINS-1:0] prev_level;
  reg  [1:0]          fill;
  wire                primed;
  wire [NUM_PINS-1:0] changed;
  // Sleep tracking
  reg  [2:0]          state;
  reg  [2:0]          next_state;
  reg  [NUM_PINS-1:0] sleep_ref;
  reg  [NUM_PINS-1:0] next_sleep_ref;
  wire                asleep;
  wire                sleep_entry;
  wire [NUM_PINS-1:0] sleep_diff;
  wire                sleep_hit;
  // Next values of the registered outputs
  reg  [NUM_PINS-1:0] next_change;
  reg                 next_irq;
  wire                next_wake;

  assign enable     = pick_pins(CHANGE_IRQ_ENABLE_HIGH, CHANGE_IRQ_ENABLE_LOW);
  assign pullup_req = pick_pins(WEAK_PULLUP_ENABLE_HIGH, WEAK_PULLUP_ENABLE_LOW);

  icn_sync #(
    .WIDTH (NUM_PINS)
  ) u_sync (
    .clk   (SYS_CLK),
    .reset (RESET),
    .d     (MONITORED_INPUT_PIN),
    .q     (pin_sync)
  );

  // History starts at zero, so the first compares are masked
  always @(posedge SYS_CLK) begin
    if (RESET) begin
      fill <= 2'h0;
    end else if (!primed) begin
      fill <= fill + 2'h1;
    end
  end

  assign primed = (fill == `ICN_SETTLE_CYCLES);

  always @(posedge SYS_CLK) begin
    if (RESET) begin
      prev_level <= {NUM_PINS{1'h0}};
    end else begin
      prev_level <= pin_sync;
    end
  end

  // Change compare against last captured level
  assign changed = primed ? diff_pins(pin_sync, prev_level, enable) : {NUM_PINS{1'h0}};

  // Sleep tracking: reference taken on the way in
  always @* begin
    next_state = state;
    case (state)
      ST_AWAKE: begin
        if (SLEEP) begin
          next_state = ST_ENTER;
        end
      end
      ST_ENTER: begin
        if (SLEEP) begin
          next_state = ST_ASLEEP;
        end else begin
          next_state = ST_AWAKE;
        end
      end
      ST_ASLEEP: begin
        if (!SLEEP) begin
          next_state = ST_AWAKE;
        end
      end
      default: begin
        next_state = ST_AWAKE;
      end
    endcase
  end

  always @(posedge SYS_CLK) begin
    if (RESET) begin
      state <= ST_AWAKE;
    end else begin
      state <= next_state;
    end
  end

  assign asleep      = (state == ST_ENTER) | (state == ST_ASLEEP);
  assign sleep_entry = SLEEP & (state == ST_AWAKE);

  always @* begin
    next_sleep_ref = sleep_ref;
    if (sleep_entry) begin
      next_sleep_ref = MONITORED_INPUT_PIN;
    end
  end

  always @(posedge SYS_CLK) begin
    if (RESET) begin
      sleep_ref <= {NUM_PINS{1'h0}};
    end else begin
      sleep_ref <= next_sleep_ref;
    end
  end

  // Raw pin compare: no synchroniser delay while asleep
  assign sleep_diff = diff_pins(MONITORED_INPUT_PIN, sleep_ref, enable);
  assign sleep_hit  = asleep & (|sleep_diff);
  assign next_wake  = sleep_hit;

  // Set wins over clear
  always @* begin
    if (IRQ_CLEAR) begin
      next_change = changed;
    end else begin
      next_change = PIN_STATE_CHANGE | changed;
    end
  end

  always @* begin
    if (IRQ_CLEAR) begin
      next_irq = (|changed) | sleep_hit;
    end else begin
      next_irq = (|next_change) | sleep_hit | CHANGE_IRQ;
    end
  end

  always @(posedge SYS_CLK) begin
    if (RESET) begin
      PIN_STATE_CHANGE <= {NUM_PINS{1'h0}};
    end else begin
      PIN_STATE_CHANGE <= next_change;
    end
  end

  always @(posedge SYS_CLK) begin
    if (RESET) begin
      CHANGE_IRQ <= 1'h0;
    end else begin
      CHANGE_IRQ <= next_irq;
    end
  end

  always @(posedge SYS_CLK) begin
    if (RESET) begin
      WAKE_REQUEST <= 1'h0;
    end else begin
      WAKE_REQUEST <= next_wake;
    end
  end

  always @(posedge SYS_CLK) begin
    if (RESET) begin
      PULLUP_ON <= {NUM_PINS{1'h0}};
    end else begin
      PULLUP_ON <= pullup_req;
    end
  end
endmodule // icn_notifier
`default_nettype wire

// ==== test/icn_chk_asserts.sv ====
// Port checker for icn_notifier.
// Assumes SYS_CLK and a synchronous RESET.
`timescale 1ns/10ps
`default_nettype none
module icn_chk #(parameter NUM_PINS = 21) (
  input wire logic SYS_CLK, RESET, SLEEP, IRQ_CLEAR, CHANGE_IRQ, WAKE_REQUEST,
  input wire logic [NUM_PINS-1:0] MONITORED_INPUT_PIN, PULLUP_ON, PIN_STATE_CHANGE,
  input wire logic [15:0] CHANGE_IRQ_ENABLE_LOW, CHANGE_IRQ_ENABLE_HIGH, WEAK_PULLUP_ENABLE_LOW, WEAK_PULLUP_ENABLE_HIGH);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  wire [31:0] en = {CHANGE_IRQ_ENABLE_HIGH, CHANGE_IRQ_ENABLE_LOW};
  wire [31:0] pe = {WEAK_PULLUP_ENABLE_HIGH, WEAK_PULLUP_ENABLE_LOW};
  logic [NUM_PINS-1:0] prv;
  always @(posedge SYS_CLK) prv <= MONITORED_INPUT_PIN;
  wire hit = |(en[NUM_PINS-1:0] & (MONITORED_INPUT_PIN ^ prv));
  chk_pullup_lag: assert property (!$past(RESET) |-> PULLUP_ON == $past(pe[NUM_PINS-1:0])) else $error("pull-up");
  chk_irq_cause: assert property ($rose(CHANGE_IRQ) |-> |PIN_STATE_CHANGE || WAKE_REQUEST) else $error("irq");
  chk_flag_gate: assert property (!(|(PIN_STATE_CHANGE & ~$past(PIN_STATE_CHANGE) & ~$past(en[NUM_PINS-1:0]))))
    else $error("gate");
  chk_change_seen: assert property (hit ##1 !IRQ_CLEAR[*3] |-> ##[0:1] CHANGE_IRQ) else $error("lost");
  chk_sleep_wake: assert property (SLEEP && $past(SLEEP, 2) && hit |-> ##[0:2] WAKE_REQUEST) else $error("wake");
  chk_wake_asleep: assert property (WAKE_REQUEST |-> $past(SLEEP, 2)) else $error("wake awake");
  chk_irq_sticky: assert property (CHANGE_IRQ && !IRQ_CLEAR |=> CHANGE_IRQ) else $error("irq dropped");
endmodule // icn_chk
bind icn_notifier icn_chk #(.NUM_PINS(NUM_PINS)) icn_chk_inst (
  .SYS_CLK(SYS_CLK), .RESET(RESET), .SLEEP(SLEEP), .IRQ_CLEAR(IRQ_CLEAR), .CHANGE_IRQ(CHANGE_IRQ),
  .WAKE_REQUEST(WAKE_REQUEST), .MONITORED_INPUT_PIN(MONITORED_INPUT_PIN), .PULLUP_ON(PULLUP_ON),
  .PIN_STATE_CHANGE(PIN_STATE_CHANGE), .CHANGE_IRQ_ENABLE_LOW(CHANGE_IRQ_ENABLE_LOW),
  .CHANGE_IRQ_ENABLE_HIGH(CHANGE_IRQ_ENABLE_HIGH), .WEAK_PULLUP_ENABLE_LOW(WEAK_PULLUP_ENABLE_LOW),
  .WEAK_PULLUP_ENABLE_HIGH(WEAK_PULLUP_ENABLE_HIGH));
`default_nettype wire

// ==== test/icn_pins.sv ====
// Buttons on the monitored pins.
// Assumes the bench sets the wanted levels.
`timescale 1ns/10ps
`default_nettype none
module icn_pins (
  input  wire logic        clk,
  input  wire logic [20:0] want,
  output var  logic [20:0] pin);
  initial pin = '0;
  always @(posedge clk) pin <= want;
endmodule // icn_pins
`default_nettype wire

// ==== test/tb_top.sv ====
// Bench for icn_notifier.
// Assumes the pin model and checker beside it.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk = 0, rst = 1, slp = 0, clr = 0;
  logic [20:0] want = 0, pin, r;
  logic [15:0] el = 0, eh = 0, pl = 0, ph = 0;
  wire  [20:0] pu, flg;
  wire         irq, wk;
  int          n_errors = 0, samples_checked = 0;
  logic [20:0] rows [3] = '{21'h1fffff, 21'h000001, 21'h100000};
  always #5 clk = ~clk;
  icn_pins icn_pins_inst (.clk(clk), .want(want), .pin(pin));
  icn_notifier icn_notifier_inst (.SYS_CLK(clk), .RESET(rst), .SLEEP(slp), .MONITORED_INPUT_PIN(pin),
    .CHANGE_IRQ_ENABLE_LOW(el), .CHANGE_IRQ_ENABLE_HIGH(eh), .WEAK_PULLUP_ENABLE_LOW(pl),
    .WEAK_PULLUP_ENABLE_HIGH(ph), .IRQ_CLEAR(clr), .PULLUP_ON(pu), .CHANGE_IRQ(irq),
    .WAKE_REQUEST(wk), .PIN_STATE_CHANGE(flg));
  task chk(input logic [22:0] s, input logic [22:0] e);
    samples_checked++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH %0t got %h want %h", $time, s, e);
    end
  endtask
  task wrap_up;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    #1 rst = 0;
    chk({irq, flg}, 0);
    foreach (rows[i]) begin
      r = rows[i];
      @(posedge clk);
      #1 {eh, el} = {11'h0, r};
      {ph, pl} = {11'h0, r};
      clr = 1;
      @(posedge clk);
      #1 clr = 0;
      want = ~want;
      repeat (5) @(posedge clk);
      #1 chk({irq, flg}, {1'b1, r});
      chk(pu, r);
      $display("row %0d done", i);
    end
    slp = 1;
    clr = 1;
    repeat (2) @(posedge clk);
    #1 clr = 0;
    want = want ^ 21'h100001;
    repeat (5) @(posedge clk);
    #1 chk(wk, 1);
    chk(flg, 21'h100000);
    $display("sleep done");
    slp = 0;
    rst = 1;
    {eh, el} = {11'h0, 21'h1fffff};
    repeat (2) @(posedge clk);
    #1 rst = 0;
    chk({wk, irq, flg}, 0);
    chk(pu, 0);
    repeat (5) @(posedge clk);
    #1 chk({wk, irq, flg}, 0);
    chk(pu, 21'h100000);
    $display("reset done");
    want = want ^ 21'h000002;
    repeat (3) @(posedge clk);
    #1 clr = 1;
    @(posedge clk);
    #1 clr = 0;
    chk({irq, flg}, {1'b1, 21'h000002});
    @(posedge clk);
    #1 clr = 1;
    @(posedge clk);
    #1 clr = 0;
    chk({irq, flg}, 0);
    $display("clear done");
    {eh, el} = 32'hffe00000;
    want = ~want;
    repeat (5) @(posedge clk);
    #1 chk({irq, flg}, 0);
    $display("upper done");
    wrap_up();
  end
  initial begin
    #5000;
    n_errors++;
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
